// [logic/hpss_cfg.svh]
// Constants for the hot-plug slot status and control register block.
// Assumes AXI4-Lite software access with 32-bit data on one clock.
//
// What this block does
// - Interlock toggle bit 11 reads zero; writing one toggles interlock, zero does nothing.
// - Without interlock capability, toggle bit is read-only zero.
// - Link-active-change enable bit 12 lets link active changes raise hot-plug events.
// - Status bit 0 set on attention button press; write one clears.
// - Status bit 1 set on power fault; write one clears.
// - Status bit 2 set on latch sensor change; write one clears.
// - Status bit 3 set on presence change; write one clears.
// - Status bit 4 set when a software command completes; write one clears.
// - Status bit 5 shows latch state, 0 closed, 1 open.
// - Status bit 6 shows presence, 0 empty, 1 present, default 1.
// - Status bit 7 shows interlock state, 0 disengaged, 1 engaged.
// - Status bit 8 set on link layer active change; write one clears.
// - Hot-plug event only while master enable bit 5 of control is set; IRQ ignores it and follows the irq mask.
`ifndef HPSS_CFG_SVH
`define HPSS_CFG_SVH

// ----------------------------------------------------------------------
// Register indices; the byte address of each is four times its index
// ----------------------------------------------------------------------
`define HPSS_CTL_INDEX        10'h058
`define HPSS_STS_INDEX        10'h05a
`define HPSS_CTL_ADDR         10'h160
`define HPSS_STS_ADDR         10'h168
`define HPSS_IRQ_STS_ADDR     10'h060
`define HPSS_IRQ_MASK_ADDR    10'h064
`define HPSS_ADDR_W           10

// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define HPSS_CTL_MASTER_EN    5
`define HPSS_CTL_ILOCK_TGL    11
`define HPSS_CTL_LINK_EN      12
`define HPSS_CTL_LOW_MASK     16'h003f

// ----------------------------------------------------------------------
// Status field positions and reset values
// ----------------------------------------------------------------------
`define HPSS_STS_LATCH        5
`define HPSS_STS_PRESENCE     6
`define HPSS_STS_ILOCK        7
`define HPSS_STS_W1C_MASK     16'h011f
`define HPSS_STS_RESET        16'h0040
`define HPSS_NUM_EVENTS       6

`endif

// [logic/hpss_pkg.sv]
// Types for the hot-plug slot status and control register block.
// Assumes the cfg header supplies all numeric constants.
package hpss_pkg;

  // Slot sensor inputs after synchronisation
  typedef struct packed {
    logic button;
    logic power_fault;
    logic latch_open;
    logic present;
    logic ilock_engaged;
    logic link_active;
    logic cmd_done;
  } hpss_sense_t;

  // AXI read/write response states
  typedef enum logic [1:0] {RESP_OKAY = 2'b00, RESP_SLVERR = 2'b10} hpss_resp_t;

endpackage

// [logic/hpss_edge.sv]
// Synchroniser and change detector for slot sensor levels.
// Assumes asynchronous inputs; two flops precede any logic.
`timescale 1ns/1ps
module hpss_edge #(
  parameter int W = 7
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pin levels in, clean levels and change pulses out
  input  wire logic [W-1:0] pins,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] change
);

  logic [W-1:0] meta_r, sync_r, last_r;
  logic [W-1:0] meta_nxt, sync_nxt, last_nxt;

  // Next values; first stage feeds only the second
  always_comb
  begin
    meta_nxt = pins;
    sync_nxt = meta_r;
    last_nxt = sync_r;
  end

  // Register stages
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      sync_r <= '0;
      last_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
    end
  end

  // Outputs from flops only
  assign level  = sync_r;
  assign rise   = sync_r & ~last_r;
  assign change = sync_r ^ last_r;

endmodule // hpss_edge

// [logic/hpss_slot.sv]
// Hot-plug slot upper control and status registers with AXI4-Lite slave.
// Assumes sensor pins are asynchronous; the link active flag is on SYS_CLK.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "hpss_cfg.svh"
module hpss_slot #(
  parameter bit ILOCK_PRESENT = 1'b1
) (
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  // AXI4-Lite write address
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [9:0]  AWADDR,
  // AXI4-Lite write data
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  // AXI4-Lite write response
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [1:0]       BRESP,
  // AXI4-Lite read address
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [9:0]  ARADDR,
  // AXI4-Lite read data
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  // Slot sensors
  input  wire logic        ATTN_BUTTON,
  input  wire logic        POWER_FAULT,
  input  wire logic        LATCH_OPEN,
  input  wire logic        CARD_PRESENT,
  input  wire logic        ILOCK_ENGAGED,
  input  wire logic        CMD_DONE,
  // Link layer active from core logic
  input  wire logic        LINK_LAYER_ACTIVE,
  // Actuators and events
  output logic             ILOCK_TOGGLE,
  output logic             HOTPLUG_EVENT,
  output logic             IRQ
);

  // --------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------
  // Control and status keep their own indices; the bus sees each one at
  // four times the index, one aligned word apiece, data in bits 15:0.
  //   control     : bits 0-5 and 12 read/write, 11 toggle (reads zero)
  //   status      : bits 0-4 and 8 sticky, write one to clear
  //                 bits 5-7 live sensor levels, read only
  //   irq status  : {link, cmd, presence, latch, power, button}, W1C
  //   irq mask    : same layout, a one lets the level interrupt through
  // Upper half of every word reads zero. A write to an unmapped word is
  // dropped and answered with an error; so is a read, with zero data.
  // Bits 6-10 of control (indicators, power) live in another block, so
  // they read zero here and writes to them are lost.
  // The link flag is taken raw: it must already be on SYS_CLK, and a
  // high level at reset release is seen as one change.

  // --------------------------------------------------------------------
  // Sensor synchronisation
  // --------------------------------------------------------------------
  hpss_pkg::hpss_sense_t pins_s, lvl_s, rise_s, chg_s;
  logic                  link_q_r, link_q_nxt;
  logic                  link_chg;

  // Pack the asynchronous pins; link bit bypasses the synchroniser
  always_comb
  begin
    pins_s               = '0;
    pins_s.button        = ATTN_BUTTON;
    pins_s.power_fault   = POWER_FAULT;
    pins_s.latch_open    = LATCH_OPEN;
    pins_s.present       = CARD_PRESENT;
    pins_s.ilock_engaged = ILOCK_ENGAGED;
    pins_s.cmd_done      = CMD_DONE;
  end

  hpss_edge #(.W(7)) u_edge (
    .clk    (SYS_CLK),
    .rst_n  (RSTN),
    .pins   (pins_s),
    .level  (lvl_s),
    .rise   (rise_s),
    .change (chg_s)
  );

  // Link active change seen on the core clock
  assign link_q_nxt = LINK_LAYER_ACTIVE;
  assign link_chg   = link_q_r ^ LINK_LAYER_ACTIVE;

  // --------------------------------------------------------------------
  // AXI4-Lite handshake state
  // --------------------------------------------------------------------
  logic        aw_held_r, aw_held_nxt;
  logic        w_held_r, w_held_nxt;
  logic [9:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic        wr_fire;

  // Decode: true for any mapped word address
  function automatic logic hpss_mapped(input logic [9:0] a);
    hpss_mapped = (a == `HPSS_CTL_ADDR) || (a == `HPSS_STS_ADDR) ||
                  (a == `HPSS_IRQ_STS_ADDR) ||
                  (a == `HPSS_IRQ_MASK_ADDR);
  endfunction

  // One write in flight; ready drops once a channel is captured
  assign AWREADY = !aw_held_r && !bvalid_r;
  assign WREADY  = !w_held_r && !bvalid_r;
  assign ARREADY = !rvalid_r;
  assign wr_fire = aw_held_r && w_held_r;

  // --------------------------------------------------------------------
  // Slot registers
  // --------------------------------------------------------------------
  logic [15:0] ctl_r, ctl_nxt;
  logic [15:0] sts_r, sts_nxt;
  logic [5:0]  irq_sts_r, irq_sts_nxt;
  logic [5:0]  irq_mask_r, irq_mask_nxt;
  logic        tgl_r, tgl_nxt;
  logic        evt_r, evt_nxt;
  logic [15:0] sts_set, sts_clr, ctl_wmask, sts_view, ctl_view;
  logic [5:0]  ev_vec, ev_en, irq_clr;
  logic        wr_ctl, wr_sts, wr_isr, wr_imask;

  // Live status view; reserved bits read zero
  always_comb
  begin
    sts_view                      = sts_r & `HPSS_STS_W1C_MASK;
    sts_view[`HPSS_STS_LATCH]     = lvl_s.latch_open;
    sts_view[`HPSS_STS_PRESENCE]  = sts_r[`HPSS_STS_PRESENCE];
    sts_view[`HPSS_STS_ILOCK]     = ILOCK_PRESENT & lvl_s.ilock_engaged;
    ctl_view                      = ctl_r;
    ctl_view[`HPSS_CTL_ILOCK_TGL] = 1'b0;
  end

  // Control masks and write decode
  always_comb
  begin
    wr_ctl    = wr_fire && awaddr_r == `HPSS_CTL_ADDR;
    wr_sts    = wr_fire && awaddr_r == `HPSS_STS_ADDR;
    wr_isr    = wr_fire && awaddr_r == `HPSS_IRQ_STS_ADDR;
    wr_imask  = wr_fire && awaddr_r == `HPSS_IRQ_MASK_ADDR;
    ctl_wmask = `HPSS_CTL_LOW_MASK;
    ctl_wmask[`HPSS_CTL_LINK_EN] = 1'b1;
    // Event sources in status bit order
    sts_set      = '0;
    sts_set[0]   = rise_s.button;
    sts_set[1]   = rise_s.power_fault;
    sts_set[2]   = chg_s.latch_open;
    sts_set[3]   = chg_s.present;
    sts_set[4]   = rise_s.cmd_done;
    sts_set[8]   = link_chg;
    sts_clr      = '0;
    if (wr_sts && wstrb_r[0])
      sts_clr[7:0] = wdata_r[7:0];
    if (wr_sts && wstrb_r[1])
      sts_clr[15:8] = wdata_r[15:8];
    sts_clr = sts_clr & `HPSS_STS_W1C_MASK;
  end

  // Next state for control, status and interrupt registers
  always_comb
  begin
    ctl_nxt = ctl_r;
    tgl_nxt = 1'b0;
    if (wr_ctl && wstrb_r[0])
      ctl_nxt[7:0] = wdata_r[7:0] & ctl_wmask[7:0];
    if (wr_ctl && wstrb_r[1])
    begin
      ctl_nxt[15:8] = wdata_r[15:8] & ctl_wmask[15:8];
      tgl_nxt = ILOCK_PRESENT & wdata_r[`HPSS_CTL_ILOCK_TGL];
    end
    ctl_nxt[`HPSS_CTL_ILOCK_TGL] = 1'b0;
    // Set wins over a clear in the same cycle; stays until cleared
    sts_nxt = ((sts_r & ~sts_clr) | sts_set) & `HPSS_STS_W1C_MASK;
    sts_nxt[`HPSS_STS_PRESENCE] = lvl_s.present;
    // Enabled events gate the hot-plug event, master enable gates all
    ev_vec = {sts_set[8], sts_set[4:0]};
    ev_en  = {ctl_r[`HPSS_CTL_LINK_EN], ctl_r[4:0]};
    evt_nxt = ctl_r[`HPSS_CTL_MASTER_EN] && |(ev_vec & ev_en);
    irq_clr = '0;
    if (wr_isr && wstrb_r[0])
      irq_clr = wdata_r[5:0];
    irq_sts_nxt = (irq_sts_r & ~irq_clr) | ev_vec;
    irq_mask_nxt = irq_mask_r;
    if (wr_imask && wstrb_r[0])
      irq_mask_nxt = wdata_r[5:0];
  end

  // --------------------------------------------------------------------
  // Bus next state
  // --------------------------------------------------------------------
  always_comb
  begin
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (AWVALID && AWREADY)
    begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = {AWADDR[9:2], 2'b00};
    end
    if (WVALID && WREADY)
    begin
      w_held_nxt = 1'b1;
      wdata_nxt  = WDATA;
      wstrb_nxt  = WSTRB;
    end
    if (wr_fire)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = hpss_mapped(awaddr_r) ? hpss_pkg::RESP_OKAY : hpss_pkg::RESP_SLVERR;
    end
    else if (bvalid_r && BREADY)
      bvalid_nxt = 1'b0;
    if (ARVALID && ARREADY)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = hpss_pkg::RESP_OKAY;
      unique case ({ARADDR[9:2], 2'b00})
        `HPSS_CTL_ADDR:       rdata_nxt = {16'h0, ctl_view};
        `HPSS_STS_ADDR:       rdata_nxt = {16'h0, sts_view};
        `HPSS_IRQ_STS_ADDR:   rdata_nxt = {26'h0, irq_sts_r};
        `HPSS_IRQ_MASK_ADDR:  rdata_nxt = {26'h0, irq_mask_r};
        default:
        begin
          rdata_nxt = 32'h0;
          rresp_nxt = hpss_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_r && RREADY)
      rvalid_nxt = 1'b0;
  end

  // --------------------------------------------------------------------
  // Slot state registers
  // --------------------------------------------------------------------
  // Presence bit resets set; the synchroniser then pulls it to the pin
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ctl_r      <= 16'h0000;
      sts_r      <= `HPSS_STS_RESET;
      tgl_r      <= 1'b0;
      evt_r      <= 1'b0;
      link_q_r   <= 1'b0;
    end
    else
    begin
      ctl_r      <= ctl_nxt;
      sts_r      <= sts_nxt;
      tgl_r      <= tgl_nxt;
      evt_r      <= evt_nxt;
      link_q_r   <= link_q_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt registers
  // --------------------------------------------------------------------
  // Masked off after reset, so no interrupt until software opts in
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      irq_sts_r  <= 6'h00;
      irq_mask_r <= 6'h00;
    end
    else
    begin
      irq_sts_r  <= irq_sts_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Bus registers
  // --------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      aw_held_r  <= 1'b0;
      w_held_r   <= 1'b0;
      awaddr_r   <= 10'h000;
      wdata_r    <= 32'h0;
      wstrb_r    <= 4'h0;
      bvalid_r   <= 1'b0;
      bresp_r    <= 2'b00;
      rvalid_r   <= 1'b0;
      rdata_r    <= 32'h0;
      rresp_r    <= 2'b00;
    end
    else
    begin
      aw_held_r  <= aw_held_nxt;
      w_held_r   <= w_held_nxt;
      awaddr_r   <= awaddr_nxt;
      wdata_r    <= wdata_nxt;
      wstrb_r    <= wstrb_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      rvalid_r   <= rvalid_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
    end
  end

  // Outputs
  assign BVALID        = bvalid_r;
  assign BRESP         = bresp_r;
  assign RVALID        = rvalid_r;
  assign RDATA         = rdata_r;
  assign RRESP         = rresp_r;
  assign ILOCK_TOGGLE  = tgl_r;
  assign HOTPLUG_EVENT = evt_r;
  assign IRQ           = |(irq_sts_r & irq_mask_r);

endmodule // hpss_slot

// [verif/hpss_slot_props.sv]
// Checker for the slot register block: bus handshakes, read data and toggle pulse.
// Assumes it is bound to hpss_slot and sees only its ports.
`timescale 1ns/1ps
module hpss_slot_props (
  // Clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RSTN,
  // Register bus
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP,
  // Actuator
  input wire logic        ILOCK_TOGGLE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  // --------------------------------------------------------------------
  // Handshake and answer timing
  // --------------------------------------------------------------------
  a_bresp_held: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped before taken");
  a_rdata_held: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped before taken");
  a_ar_refused: assert property (RVALID |-> !ARREADY)
    else $error("read address taken while data pending");
  a_aw_refused: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");
  a_rd_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data late");
  a_wr_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:3] BVALID)
    else $error("write response late");
  // --------------------------------------------------------------------
  // Read contents; toggle bit and reserved ranges never read as one
  // --------------------------------------------------------------------
  a_unmapped_zero: assert property (RVALID && RRESP == 2'h2 |-> RDATA == 32'h0)
    else $error("unmapped read returned data");
  a_resv_zero: assert property (RVALID |-> RDATA[31:16] == 16'h0 && RDATA[15:13] == 3'h0 && !RDATA[11])
    else $error("reserved or toggle bit read as one");
  a_toggle_pulse: assert property (ILOCK_TOGGLE |=> !ILOCK_TOGGLE)
    else $error("toggle pulse longer than one cycle");
endmodule // hpss_slot_props

bind hpss_slot hpss_slot_props chk_u (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
  .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY),
  .RDATA(RDATA), .RRESP(RRESP), .ILOCK_TOGGLE(ILOCK_TOGGLE));

// [verif/hpss_sensor_model.sv]
// Slot sensors, power controller and interlock mechanism as seen by the block.
// Assumes the bench calls kick() at a clock edge; pins are static levels.
`timescale 1ns/1ps
module hpss_sensor_model (
  // Clock
  input wire logic clk,
  // Interlock drive and sensor levels
  input wire logic ilock_toggle,
  output logic [5:0] pins
);
  int lag = 1;
  // Card present from the start, everything else idle
  initial pins = 6'h08;
  // Latch and presence flip; others pulse long enough for the two-flop sync
  task automatic kick(input int k);
    if (k == 2 || k == 3)
      pins[k] <= ~pins[k];
    else
    begin
      pins[k] <= 1'b1;
      repeat (4) @(posedge clk);
      pins[k] <= 1'b0;
    end
  endtask
  // Mechanism moves after a settable lag, prompt or slow
  always @(posedge clk)
    if (ilock_toggle === 1'b1)
      fork
        begin
          repeat (lag) @(posedge clk);
          pins[4] <= ~pins[4];
        end
      join_none
endmodule // hpss_sensor_model

// [verif/hpss_slot_tb.sv]
// Self-checking bench for hpss_slot: register bus, events, interrupt, interlock.
// Assumes the sensor model drives all slot pins; the bench drives link state.
`timescale 1ns/1ps
module hpss_slot_tb;
  logic        SYS_CLK = 0, RSTN = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, link = 0;
  logic [9:0]  aw_a = 10'h0, ar_a = 10'h0;
  logic [31:0] w_d = 32'h0, rd_d, RDATA;
  logic [3:0]  w_s = 4'h0;
  logic [1:0]  BRESP, RRESP, rsp;
  logic [5:0]  pins;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, ILOCK_TOGGLE, HOTPLUG_EVENT, IRQ;
  integer      seed = 36, miscompares = 0, cmp_count = 0, ev_n = 0, tg_n = 0, i, sb, v;
  logic [31:0] ctl_tab [4] = '{32'h21, 32'h01, 32'h1020, 32'h1000};

  always #2 SYS_CLK = ~SYS_CLK;

  hpss_slot dut_u (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .AWVALID(aw_v), .AWREADY(AWREADY),
    .AWADDR(aw_a), .WVALID(w_v), .WREADY(WREADY), .WDATA(w_d), .WSTRB(w_s), .BVALID(BVALID),
    .BREADY(b_r), .BRESP(BRESP), .ARVALID(ar_v), .ARREADY(ARREADY), .ARADDR(ar_a),
    .RVALID(RVALID), .RREADY(r_r), .RDATA(RDATA), .RRESP(RRESP), .ATTN_BUTTON(pins[0]),
    .POWER_FAULT(pins[1]), .LATCH_OPEN(pins[2]), .CARD_PRESENT(pins[3]),
    .ILOCK_ENGAGED(pins[4]), .CMD_DONE(pins[5]), .LINK_LAYER_ACTIVE(link),
    .ILOCK_TOGGLE(ILOCK_TOGGLE), .HOTPLUG_EVENT(HOTPLUG_EVENT), .IRQ(IRQ));
  hpss_sensor_model sm_u (.clk(SYS_CLK), .ilock_toggle(ILOCK_TOGGLE), .pins(pins));

  // Pulse counters; a wide pulse would count twice
  always @(posedge SYS_CLK)
  begin
    if (HOTPLUG_EVENT === 1'b1) ev_n++;
    if (ILOCK_TOGGLE === 1'b1) tg_n++;
  end

  // Expected level bits of the status word: latch, presence, interlock
  function automatic logic [31:0] lv();
    return {24'h0, pins[4], pins[3], pins[2], 5'h0};
  endfunction

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", n, exp, seen);
    end
  endtask

  // Write: address and data offered together, response taken after a random stall
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
    logic pa, pw;
    int   st;
    @(posedge SYS_CLK);
    aw_v <= 1'b1; w_v <= 1'b1; aw_a <= a; w_d <= d; w_s <= s;
    pa = 1'b1; pw = 1'b1; st = $unsigned($random(seed)) % 3;
    while (pa || pw)
    begin
      @(posedge SYS_CLK);
      if (pa && AWREADY === 1'b1) begin pa = 1'b0; aw_v <= 1'b0; end
      if (pw && WREADY === 1'b1) begin pw = 1'b0; w_v <= 1'b0; end
    end
    repeat (st) @(posedge SYS_CLK);
    b_r <= 1'b1;
    do @(posedge SYS_CLK); while (BVALID !== 1'b1);
    rsp = BRESP; b_r <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a);
    int st;
    @(posedge SYS_CLK);
    ar_v <= 1'b1; ar_a <= a; st = $unsigned($random(seed)) % 3;
    do @(posedge SYS_CLK); while (ARREADY !== 1'b1);
    ar_v <= 1'b0;
    repeat (st) @(posedge SYS_CLK);
    r_r <= 1'b1;
    do @(posedge SYS_CLK); while (RVALID !== 1'b1);
    rd_d = RDATA; rsp = RRESP; r_r <= 1'b0;
  endtask

  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge SYS_CLK);
    miscompares++;
    report_and_stop;
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    repeat (10) @(posedge SYS_CLK);
    // Sync flops may flag a presence edge out of reset; clear first
    wr(10'h168, 32'h011f, 4'h3);
    wr(10'h060, 32'h3f, 4'h1);
    rd(10'h168); chk("slot_status", rd_d, lv());
    rd(10'h064); chk("irq_mask", rd_d, 32'h0);
    rd(10'h010); chk("unmapped_rd", {rd_d[29:0], rsp}, 32'h2);
    wr(10'h010, 32'hffffffff, 4'hf); chk("unmapped_wr", {30'h0, rsp}, 32'h2);
    // Random control values, toggle bit held low
    repeat (8)
    begin
      v = $random(seed);
      wr(10'h160, v & 32'h0000f7ff, 4'h3);
      rd(10'h160); chk("ctl", rd_d, v & 32'h103f);
    end
    chk("no_toggle", tg_n, 0);
    wr(10'h160, 32'h0, 4'h3);
    // Interlock toggled twice, prompt then slow mechanism
    for (i = 0; i < 2; i++)
    begin
      sm_u.lag = 1 + 4 * i;
      wr(10'h160, 32'h800, 4'h3);
      repeat (10) @(posedge SYS_CLK);
      rd(10'h168); chk("ilock", rd_d, lv());
      chk("ilock_st", rd_d[7], i == 0);
    end
    chk("toggles", tg_n, 2);
    // Every slot event: flag, level, interrupt, mask, sticky, clear
    wr(10'h064, 32'h3f, 4'h1);
    for (i = 0; i < 6; i++)
    begin
      sb = (i == 5) ? 8 : i;
      if (i == 5) link <= ~link;
      else sm_u.kick(i == 4 ? 5 : i);
      repeat (8) @(posedge SYS_CLK);
      rd(10'h168); chk("flag", rd_d, lv() | (32'h1 << sb));
      chk("irq_on", IRQ, 1'b1);
      wr(10'h064, 32'h0, 4'h1); chk("irq_masked", IRQ, 1'b0);
      wr(10'h064, 32'h3f, 4'h1);
      wr(10'h168, 32'h0, 4'h3); wr(10'h060, 32'h0, 4'h1);
      rd(10'h060); chk("irq_sts", rd_d, 32'h1 << i);
      rd(10'h168); chk("sticky", rd_d, lv() | (32'h1 << sb));
      wr(10'h168, 32'h1 << sb, 4'h3); wr(10'h060, 32'h1 << i, 4'h1);
      rd(10'h168); chk("cleared", rd_d, lv());
      chk("irq_off", IRQ, 1'b0);
    end
    chk("ev_quiet", ev_n, 0);
    // Event output gated by master enable, button then link change
    for (i = 0; i < 4; i++)
    begin
      wr(10'h160, ctl_tab[i], 4'h3);
      v = ev_n;
      if (i < 2) sm_u.kick(0);
      else link <= ~link;
      repeat (10) @(posedge SYS_CLK);
      chk("hp_event", ev_n - v, (i + 1) % 2);
      wr(10'h168, 32'h011f, 4'h3);
    end
    report_and_stop;
  end
endmodule // hpss_slot_tb
